/* File: src/asr_pkg.sv */
// shared constants and types of the converter status and control bank
package asr_pkg;
  // register select codes
  localparam logic [3:0] RS_STATUS = 4'h0;
  localparam logic [3:0] RS_CONFIG = 4'h1;
  localparam logic [3:0] RS_GPIO = 4'h2;
  localparam logic [3:0] RS_GAINCAL = 4'h3;
  localparam logic [3:0] RS_RESULT = 4'h4;
  localparam logic [3:0] RS_SYS_OFF = 4'h5;
  localparam logic [3:0] RS_SYS_GAIN = 4'h6;
  localparam logic [3:0] RS_SELF_OFF = 4'h7;
  localparam logic [3:0] RS_SELF_GAIN = 4'h8;
  localparam int unsigned REG_COUNT = 9;
  // power-on values and writable masks
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h02;
  localparam logic [7:0] RST_GPIO = 8'h0F;
  localparam logic [7:0] RST_GAINCAL = 8'h1E;
  localparam logic [23:0] RST_WIDE = 24'h000000;
  localparam logic [7:0] CONFIG_MASK = 8'hFE;
  localparam logic [7:0] GAINCAL_MASK = 8'hFE;
  localparam logic [23:0] GAIN_COEF_MAX = 24'hFFFFFF;
  // converter_config field positions
  localparam int unsigned CFG_LINE_FREQUENCY_SELECT = 7;
  localparam int unsigned CFG_POLARITY = 6;
  localparam int unsigned CFG_CLKSRC = 5;
  localparam int unsigned CFG_REFERENCE_BUFFER_ENABLE = 4;
  localparam int unsigned CFG_SIGNAL_BUFFER_ENABLE = 3;
  localparam int unsigned CFG_FORMAT = 2;
  localparam int unsigned CFG_SINGLE_CYCLE_SELECT = 1;
  // gain_cal_control digital gain field
  localparam int unsigned GAIN_HI = 7;
  localparam int unsigned GAIN_LO = 5;
  // command byte layout
  localparam int unsigned CMD_START = 7;
  localparam int unsigned CMD_MODE = 6;
  localparam int unsigned CMD_ZERO = 5;
  localparam int unsigned CMD_RS_HI = 4;
  localparam int unsigned CMD_RS_LO = 1;
  localparam int unsigned CMD_RW = 0;
  localparam int unsigned CMD_CAL_HI = 5;
  localparam int unsigned CMD_CAL_LO = 4;
  localparam int unsigned CMD_IMPD = 3;
  localparam int unsigned CMD_RATE_HI = 2;
  localparam logic RW_READ = 1'b1;
  // frame bit counts
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] SHORT_BITS = 6'h08;
  localparam logic [5:0] LONG_BITS = 6'h18;
  // conversion timing
  localparam logic [1:0] SETTLE_RESULTS = 2'h3;
  localparam int unsigned CONV_CYCLES_DEF = 16;
  // modulator operations, in calibration field order
  typedef enum logic [1:0] {
    OP_CONVERT, OP_SELF_CAL, OP_SYS_OFF, OP_SYS_GAIN
  } asr_op_t;
endpackage

/* File: src/asr_sync2.sv */
// two flip-flop level synchroniser into the system clock
`timescale 1ns/1ns
module asr_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input logic clk_sys,
  input logic rst_n,
  input logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // asr_sync2

/* File: src/asr_conv_seq.sv */
// modulator sequencer: conversion and calibration timing
`timescale 1ns/1ns
module asr_conv_seq #(
  parameter int unsigned CONV_CYCLES = asr_pkg::CONV_CYCLES_DEF
) (
  input logic clk_sys,
  input logic rst_n,
  input logic start,
  input logic stop,
  input logic single_cycle,
  input asr_pkg::asr_op_t op_in,
  output logic busy,
  output logic done,
  output asr_pkg::asr_op_t op_out
);
  import asr_pkg::*;

  typedef enum logic {ST_IDLE, ST_RUN} asr_seq_state_t;
  asr_seq_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [1:0] settle_reg;

  wire cnt_end = cnt_reg == 16'(CONV_CYCLES - 1);
  wire settling = !single_cycle && settle_reg != SETTLE_RESULTS;
  assign busy = state_reg == ST_RUN;

  // one operation per start; continuous mode restarts itself
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 16'h0000;
      settle_reg <= 2'h0;
      done <= 1'b0;
      op_out <= OP_CONVERT;
    end
    else
    begin
      done <= 1'b0;
      if (stop)
        state_reg <= ST_IDLE;
      else if (start)
      begin
        state_reg <= ST_RUN;
        op_out <= op_in;
        cnt_reg <= 16'h0000;
        settle_reg <= 2'h0;
      end
      else
      begin
        unique case (state_reg)
          ST_IDLE: cnt_reg <= 16'h0000;
          ST_RUN:
          begin
            cnt_reg <= cnt_end ? 16'h0000 : cnt_reg + 16'h0001;
            if (cnt_end && op_out != OP_CONVERT)
            begin
              done <= 1'b1;
              state_reg <= ST_IDLE;
            end
            else if (cnt_end && settling)
              settle_reg <= settle_reg + 2'h1;
            else if (cnt_end)
            begin
              done <= 1'b1;
              if (single_cycle)
                state_reg <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule // asr_conv_seq

/* File: src/asr_status_regs.sv */
// converter register bank behind the four-wire serial port
`timescale 1ns/1ns
module asr_status_regs #(
  parameter int unsigned CONV_CYCLES = asr_pkg::CONV_CYCLES_DEF
) (
  input logic clk_sys,
  input logic rst_n,
  input logic sclk,
  input logic cs_n,
  input logic din,
  output logic rdy_dout,
  output logic rdy_dout_oe,
  input logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  input logic [23:0] raw_result,
  input logic raw_over,
  input logic raw_under,
  input logic cal_over,
  output logic line_frequency_select,
  output logic unipolar_select,
  output logic clock_source_select,
  output logic reference_buffer_enable,
  output logic signal_buffer_enable,
  output logic single_cycle_select,
  output logic [2:0] digital_gain_field
);
  import asr_pkg::*;
  // link side state
  logic [5:0] bit_cnt_reg;
  logic [7:0] cmd_reg, hold_cmd_reg;
  logic [23:0] shin_reg, shout_reg, hold_word_reg;
  logic out_active_reg, wr_tgl_reg, rd_tgl_reg, op_tgl_reg;
  logic [3:0] hold_rs_reg;
  // system side state
  logic [7:0] sync_q, cfg_reg, gpio_reg, gain_reg;
  logic [2:0] prev_tgl_reg, rate_reg, cur_rate_reg;
  logic [23:0] result_reg, sys_off_reg, sys_gain_reg;
  logic [23:0] self_off_reg, self_gain_reg;
  logic calor_reg, ovr_reg, undr_reg, rdy_reg, read_pend_reg, eoc_reg, oe_reg;
  logic [23:0] image_word [REG_COUNT];
  logic [23:0] snap_word [REG_COUNT];
  logic seq_busy, seq_done;
  asr_op_t seq_op;
  // command byte and frame decode on the link clock
  wire link_rst_n = rst_n & ~cs_n;
  wire [7:0] cmd_full = {cmd_reg[6:0], din};
  wire [23:0] word_full = {shin_reg[22:0], din};
  wire is_access = cmd_reg[CMD_START] & cmd_reg[CMD_MODE]
    & ~cmd_reg[CMD_ZERO];
  wire [3:0] link_rs = cmd_reg[CMD_RS_HI:CMD_RS_LO];
  wire is_read = cmd_reg[CMD_RW] == RW_READ;
  wire [5:0] data_bits = (link_rs >= RS_RESULT) ? LONG_BITS : SHORT_BITS;
  wire cmd_last = bit_cnt_reg == CMD_BITS - 6'h01;
  wire data_last = is_access
    && bit_cnt_reg == CMD_BITS + data_bits - 6'h01;
  wire is_opcmd = cmd_full[CMD_START] & ~cmd_full[CMD_MODE];
  wire out_load = bit_cnt_reg == CMD_BITS && is_access && is_read;
  wire mapped_rs = link_rs <= RS_SELF_GAIN;
  wire [23:0] read_word = mapped_rs ? snap_word[link_rs] : 24'h000000;
  // frame counter and input shifters, cleared while select is high
  always_ff @(posedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt_reg <= 6'h00;
      cmd_reg <= 8'h00;
      shin_reg <= 24'h000000;
    end
    else
    begin
      if (bit_cnt_reg != 6'h3F)
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      if (bit_cnt_reg < CMD_BITS)
        cmd_reg <= cmd_full;
      else
        shin_reg <= word_full;
    end
  end
  // frame results held past the frame and flagged by toggles
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
      op_tgl_reg <= 1'b0;
      hold_rs_reg <= 4'h0;
      hold_word_reg <= 24'h000000;
      hold_cmd_reg <= 8'h00;
    end
    else
    begin
      if (cmd_last && is_opcmd)
      begin
        hold_cmd_reg <= cmd_full;
        op_tgl_reg <= ~op_tgl_reg;
      end
      if (data_last && !is_read)
      begin
        hold_rs_reg <= link_rs;
        hold_word_reg <= word_full;
        wr_tgl_reg <= ~wr_tgl_reg;
      end
      if (data_last && is_read && link_rs == RS_RESULT)
        rd_tgl_reg <= ~rd_tgl_reg;
    end
  end
  // read data changes on the falling link edge, top bit first
  always_ff @(negedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      shout_reg <= 24'h000000;
      out_active_reg <= 1'b0;
    end
    else if (out_load)
    begin
      shout_reg <= read_word;
      out_active_reg <= 1'b1;
    end
    else
      shout_reg <= {shout_reg[22:0], 1'b0};
  end
  // select, toggles and gpio pins into the system clock
  asr_sync2 #(.WIDTH(8), .RST_VAL(8'h01)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({gpio_in, op_tgl_reg, rd_tgl_reg, wr_tgl_reg, cs_n}),
    .q(sync_q)
  );
  // event and write decode on the system clock
  wire cs_idle = sync_q[0];
  wire wr_evt = sync_q[1] ^ prev_tgl_reg[0];
  wire rd_evt = sync_q[2] ^ prev_tgl_reg[1];
  wire op_evt = sync_q[3] ^ prev_tgl_reg[2];
  wire wr_cfg = wr_evt && hold_rs_reg == RS_CONFIG;
  wire wr_gpio = wr_evt && hold_rs_reg == RS_GPIO;
  wire wr_gain = wr_evt && hold_rs_reg == RS_GAINCAL;
  wire wr_soff = wr_evt && hold_rs_reg == RS_SYS_OFF;
  wire wr_sgain = wr_evt && hold_rs_reg == RS_SYS_GAIN;
  wire wr_coff = wr_evt && hold_rs_reg == RS_SELF_OFF;
  wire wr_cgain = wr_evt && hold_rs_reg == RS_SELF_GAIN;
  wire start_req = op_evt & ~hold_cmd_reg[CMD_IMPD];
  wire stop_req = op_evt & hold_cmd_reg[CMD_IMPD];
  wire [1:0] cal_field = hold_cmd_reg[CMD_CAL_HI:CMD_CAL_LO];
  wire [2:0] cmd_rate = hold_cmd_reg[CMD_RATE_HI:0];
  wire publish = seq_done && seq_op == OP_CONVERT;
  wire cal_done = seq_done && seq_op != OP_CONVERT;
  wire rdy_clear = (rd_evt & seq_busy) | (start_req & read_pend_reg);
  wire bipolar_offset = ~cfg_reg[CFG_POLARITY] & cfg_reg[CFG_FORMAT];
  wire [23:0] fmt_result = bipolar_offset
    ? {~raw_result[23], raw_result[22:0]} : raw_result;
  wire [3:0] gpio_dir = gpio_reg[7:4];
  wire [3:0] gpio_val = (gpio_dir & gpio_reg[3:0])
    | (~gpio_dir & sync_q[7:4]);
  wire [7:0] status_byte = {calor_reg, rate_reg, ovr_reg, undr_reg,
    seq_busy, rdy_reg};
  // modulator timing
  asr_conv_seq #(.CONV_CYCLES(CONV_CYCLES)) u_seq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(start_req),
    .stop(stop_req),
    .single_cycle(cfg_reg[CFG_SINGLE_CYCLE_SELECT]),
    .op_in(asr_op_t'(cal_field)),
    .busy(seq_busy),
    .done(seq_done),
    .op_out(seq_op)
  );
  // byte registers written by the host
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_tgl_reg <= 3'h0;
      cfg_reg <= RST_CONFIG;
      gpio_reg <= RST_GPIO;
      gain_reg <= RST_GAINCAL;
    end
    else
    begin
      prev_tgl_reg <= sync_q[3:1];
      if (wr_cfg)
        cfg_reg <= hold_word_reg[7:0] & CONFIG_MASK;
      if (wr_gpio)
        gpio_reg <= hold_word_reg[7:0];
      if (wr_gain)
        gain_reg <= hold_word_reg[7:0] & GAINCAL_MASK;
    end
  end
  // wide registers; a calibration result beats a host write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_reg <= RST_WIDE;
      sys_off_reg <= RST_WIDE;
      sys_gain_reg <= RST_WIDE;
      self_off_reg <= RST_WIDE;
      self_gain_reg <= RST_WIDE;
    end
    else
    begin
      if (publish)
        result_reg <= fmt_result;
      if (cal_done && seq_op == OP_SYS_OFF)
        sys_off_reg <= raw_result;
      else if (wr_soff)
        sys_off_reg <= hold_word_reg;
      if (cal_done && seq_op == OP_SYS_GAIN)
        sys_gain_reg <= raw_result;
      else if (wr_sgain)
        sys_gain_reg <= hold_word_reg;
      if (cal_done && seq_op == OP_SELF_CAL)
        self_off_reg <= raw_result;
      else if (wr_coff)
        self_off_reg <= hold_word_reg;
      if (cal_done && seq_op == OP_SYS_GAIN && cal_over)
        self_gain_reg <= GAIN_COEF_MAX;
      else if (wr_cgain)
        self_gain_reg <= hold_word_reg;
    end
  end
  // status flags; a new result wins over a clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calor_reg <= 1'b0;
      rate_reg <= 3'h0;
      cur_rate_reg <= 3'h0;
      ovr_reg <= 1'b0;
      undr_reg <= 1'b0;
      rdy_reg <= 1'b0;
      read_pend_reg <= 1'b0;
    end
    else
    begin
      if (start_req)
        cur_rate_reg <= cmd_rate;
      if (seq_done)
        rate_reg <= cur_rate_reg;
      if (cal_done && seq_op == OP_SYS_GAIN)
        calor_reg <= cal_over;
      if (publish)
      begin
        ovr_reg <= raw_over;
        undr_reg <= raw_under;
      end
      if (publish)
        rdy_reg <= 1'b1;
      else if (rdy_clear)
        rdy_reg <= 1'b0;
      if (publish || start_req)
        read_pend_reg <= 1'b0;
      else if (rd_evt && !seq_busy)
        read_pend_reg <= 1'b1;
    end
  end
  // ready level and pin enable for the shared output
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eoc_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      eoc_reg <= rdy_reg;
      oe_reg <= ~cs_idle;
    end
  end
  // read images, left aligned, frozen while a frame is open
  assign image_word[0] = {status_byte, 16'h0000};
  assign image_word[1] = {cfg_reg, 16'h0000};
  assign image_word[2] = {gpio_dir, gpio_val, 16'h0000};
  assign image_word[3] = {gain_reg, 16'h0000};
  assign image_word[4] = result_reg;
  assign image_word[5] = sys_off_reg;
  assign image_word[6] = sys_gain_reg;
  assign image_word[7] = self_off_reg;
  assign image_word[8] = self_gain_reg;
  for (genvar i = 0; i < REG_COUNT; i++)
  begin : g_snap
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        snap_word[i] <= RST_WIDE;
      else if (cs_idle)
        snap_word[i] <= image_word[i];
    end
  end
  // pins and configuration outputs
  assign rdy_dout = out_active_reg ? shout_reg[23] : eoc_reg;
  assign rdy_dout_oe = oe_reg;
  assign gpio_out = gpio_reg[3:0];
  assign gpio_oe = gpio_dir;
  assign line_frequency_select = cfg_reg[CFG_LINE_FREQUENCY_SELECT];
  assign unipolar_select = cfg_reg[CFG_POLARITY];
  assign clock_source_select = cfg_reg[CFG_CLKSRC];
  assign reference_buffer_enable = cfg_reg[CFG_REFERENCE_BUFFER_ENABLE];
  assign signal_buffer_enable = cfg_reg[CFG_SIGNAL_BUFFER_ENABLE];
  assign single_cycle_select = cfg_reg[CFG_SINGLE_CYCLE_SELECT];
  assign digital_gain_field = gain_reg[GAIN_HI:GAIN_LO];

  // checks on the system clock
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_rdy_on_result: assert property (publish |=> rdy_reg)
    else $error("ready not set by result");
  a_rdy_busy_read: assert property
    (rd_evt && seq_busy && !publish |=> !rdy_reg)
    else $error("ready kept after read in conversion");
  a_rdy_unread_keep: assert property
    (start_req && rdy_reg && !read_pend_reg |=> rdy_reg)
    else $error("unread ready lost at start");
  a_ovr_follow: assert property
    (publish |=> ovr_reg == $past(raw_over))
    else $error("overrange flag wrong");
  a_undr_follow: assert property
    (publish |=> undr_reg == $past(raw_under))
    else $error("underrange flag wrong");
  a_cfg_write: assert property (wr_cfg |=>
    cfg_reg == ($past(hold_word_reg[7:0]) & CONFIG_MASK))
    else $error("config write lost");
  a_unmapped_quiet: assert property (wr_evt && hold_rs_reg > RS_SELF_GAIN
    && !seq_done |=> $stable(self_gain_reg) && $stable(cfg_reg))
    else $error("unmapped write changed a register");
  a_result_ro: assert property (wr_evt && hold_rs_reg == RS_RESULT
    && !publish |=> $stable(result_reg))
    else $error("result register written");
  a_calor_set: assert property (cal_done && seq_op == OP_SYS_GAIN
    && cal_over |=> calor_reg ##0 self_gain_reg == GAIN_COEF_MAX)
    else $error("calibration overrange not flagged");
  a_busy_start: assert property (start_req |=> status_byte[1])
    else $error("busy not shown after start");
endmodule // asr_status_regs

/* File: test/asr_host_bfm.sv */
// host serial master model for the converter register link
`timescale 1ns/1ns
module asr_host_bfm (
  input wire logic clk_sys,
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic rdy_dout,
  input wire logic rdy_dout_oe,
  output logic rd_valid,
  output logic [23:0] rd_data
);
  logic last_reg;
  wire line;
  // a released line shows the inverse of its last driven level
  assign line = rdy_dout_oe ? rdy_dout : ~last_reg;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    rd_valid = 1'b0;
    rd_data = 24'h000000;
    last_reg = 1'b0;
  end
  // remember what the device last drove
  always @(posedge clk_sys)
    if (rdy_dout_oe === 1'b1)
      last_reg <= rdy_dout;
  // one frame: command byte then nb data bits; sclk idles low between frames
  task automatic frame(input logic [7:0] cmd, input logic [23:0] wd,
    input int nb, input bit rd);
    logic [23:0] sh;
    sh = 24'h000000;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #7;
    for (int i = 0; i < 8 + nb; i++)
    begin
      din = (i < 8) ? cmd[7 - i] : wd[nb + 7 - i];
      #16 sclk = 1'b1;
      sh = {sh[22:0], line};
      #16 sclk = 1'b0;
    end
    @(posedge clk_sys);
    cs_n <= 1'b1;
    if (rd)
    begin
      rd_data <= (nb == 8) ? {16'h0000, sh[7:0]} : sh;
      rd_valid <= 1'b1;
      @(posedge clk_sys);
      rd_valid <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
  endtask
  // keep select low and count cycles until the ready line rises
  task automatic wait_rdy(output int cyc);
    logic prev;
    bit hit;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    prev = 1'b1;
    cyc = 0;
    do
    begin
      @(negedge clk_sys);
      cyc++;
      hit = (prev === 1'b0) && (line === 1'b1);
      prev = line;
    end while (!hit && cyc < 2000);
    @(posedge clk_sys);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule  // asr_host_bfm

/* File: test/testbench.sv */
// self-checking bench for the converter register bank
`timescale 1ns/1ns
module testbench;
  import asr_pkg::*;
  localparam int CONV = 100;
  typedef struct {logic [23:0] val; logic [23:0] mask;} asr_exp_t;
  logic clk_sys = 1'b0;
  logic rst_n, sclk, cs_n, din, rdy_dout, rdy_dout_oe, rd_valid;
  logic raw_over, raw_under, cal_over;
  logic [3:0] gpio_in, gpio_out, gpio_oe;
  logic [23:0] raw_result, rd_data;
  logic lf, uni, cks, rbuf, sbuf, scyc;
  logic [2:0] dgain;
  wire [7:0] cfg_out;
  logic [15:0] lfsr = 16'h3E8F;
  asr_exp_t exp_q[$];
  asr_exp_t e_cur;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  assign cfg_out = {lf, uni, cks, rbuf, sbuf, 1'b0, scyc, 1'b0};
  always #50 clk_sys = ~clk_sys;
  asr_status_regs #(.CONV_CYCLES(CONV)) i_asr_status_regs (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .rdy_dout(rdy_dout), .rdy_dout_oe(rdy_dout_oe), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .raw_result(raw_result),
    .raw_over(raw_over), .raw_under(raw_under), .cal_over(cal_over),
    .line_frequency_select(lf), .unipolar_select(uni),
    .clock_source_select(cks), .reference_buffer_enable(rbuf),
    .signal_buffer_enable(sbuf), .single_cycle_select(scyc),
    .digital_gain_field(dgain));
  asr_host_bfm i_asr_host_bfm (
    .clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .din(din),
    .rdy_dout(rdy_dout), .rdy_dout_oe(rdy_dout_oe), .rd_valid(rd_valid),
    .rd_data(rd_data));
  // pseudo-random source
  function automatic logic [23:0] rnd();
    logic [23:0] r;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    r[23:16] = lfsr[7:0];
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    r[15:0] = lfsr;
    return r;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // register access helpers; reads note their expectation first
  task automatic rd(input logic [3:0] s, input logic [23:0] v,
    input logic [23:0] m);
    exp_q.push_back('{v, m});
    i_asr_host_bfm.frame({3'b110, s, RW_READ}, 24'h000000,
      (s < 4'h4) ? 8 : 24, 1'b1);
  endtask
  task automatic wr(input logic [3:0] s, input logic [23:0] v);
    i_asr_host_bfm.frame({3'b110, s, ~RW_READ}, v, (s < 4'h4) ? 8 : 24, 1'b0);
  endtask
  task automatic op(input logic [7:0] c);
    i_asr_host_bfm.frame(c, 24'h000000, 0, 1'b0);
  endtask
  // compare each read result with the oldest note
  always @(posedge clk_sys)
    if (rd_valid === 1'b1)
    begin
      e_cur = exp_q.pop_front();
      check(rd_data & e_cur.mask, e_cur.val & e_cur.mask);
    end
  // watchdog
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      test_done();
    end
  end
  initial
  begin
    logic [23:0] v, raw1, raw2;
    int cyc;
    rst_n = 1'b0;
    raw_result = 24'h000000;
    raw_over = 1'b0;
    raw_under = 1'b0;
    cal_over = 1'b0;
    v = rnd();
    gpio_in = v[3:0];
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    check({16'h0000, cfg_out}, 24'h000002);
    check({13'h0000, dgain, gpio_oe, gpio_out}, 24'h00000F);
    for (int s = 0; s < 10; s++)
      rd(s[3:0], (s == 1) ? 24'h000002 : (s == 2) ? {20'h0, gpio_in} :
        (s == 3) ? 24'h00001E : 24'h000000, 24'hFFFFFF);
    $display("reset image test done");
    v = rnd();
    wr(RS_CONFIG, v);
    check({16'h0000, cfg_out}, {16'h0000, v[7:0] & 8'hFA});
    rd(RS_CONFIG, {16'h0000, v[7:0] & CONFIG_MASK}, 24'hFFFFFF);
    v = rnd();
    wr(RS_GAINCAL, v);
    check({21'h000000, dgain}, {21'h000000, v[7:5]});
    rd(RS_GAINCAL, {16'h0000, v[7:0] & GAINCAL_MASK}, 24'hFFFFFF);
    wr(RS_GPIO, 24'h00005A);
    check({16'h0000, gpio_oe, gpio_out}, 24'h00005A);
    rd(RS_GPIO, {16'h0000, 4'h5, gpio_in & 4'hA}, 24'hFFFFFF);
    for (int s = 5; s < 9; s++)
    begin
      v = rnd();
      wr(s[3:0], v);
      rd(s[3:0], v, 24'hFFFFFF);
    end
    wr(RS_STATUS, 24'h0000FF);
    wr(RS_RESULT, 24'h5A5A5A);
    wr(4'h9, 24'hFFFFFF);
    rd(RS_STATUS, 24'h000000, 24'hFFFFFF);
    rd(RS_RESULT, 24'h000000, 24'hFFFFFF);
    rd(4'h9, 24'h000000, 24'hFFFFFF);
    rd(RS_SELF_GAIN, v, 24'hFFFFFF);
    $display("register access test done");
    // bipolar offset binary, single cycle
    wr(RS_CONFIG, 24'h000006);
    raw1 = rnd();
    raw_result <= raw1;
    raw_over <= 1'b1;
    op(8'h83);
    rd(RS_STATUS, 24'h000002, 24'hFFFFFF);
    i_asr_host_bfm.wait_rdy(cyc);
    check({23'h000000, cyc < 2 * CONV}, 24'h000001);
    rd(RS_STATUS, 24'h000039, 24'hFFFFFF);
    rd(RS_RESULT, raw1 ^ 24'h800000, 24'hFFFFFF);
    rd(RS_STATUS, 24'h000039, 24'hFFFFFF);
    raw2 = rnd();
    raw_result <= raw2;
    raw_over <= 1'b0;
    raw_under <= 1'b1;
    op(8'h85);
    rd(RS_STATUS, 24'h00003A, 24'hFFFFFF);
    i_asr_host_bfm.wait_rdy(cyc);
    rd(RS_STATUS, 24'h000055, 24'hFFFFFF);
    raw1 = rnd();
    raw_result <= raw1;
    op(8'h85);
    rd(RS_STATUS, 24'h000057, 24'hFFFFFF);
    rd(RS_RESULT, raw2 ^ 24'h800000, 24'hFFFFFF);
    rd(RS_STATUS, 24'h000056, 24'hFFFFFF);
    i_asr_host_bfm.wait_rdy(cyc);
    rd(RS_RESULT, raw1 ^ 24'h800000, 24'hFFFFFF);
    $display("single conversion test done");
    cal_over <= 1'b1;
    op(8'hB0);
    repeat (CONV + 10) @(posedge clk_sys);
    rd(RS_SYS_GAIN, raw1, 24'hFFFFFF);
    rd(RS_SELF_GAIN, 24'hFFFFFF, 24'hFFFFFF);
    rd(RS_STATUS, 24'h000080, 24'h0000F2);
    rd(RS_RESULT, raw1 ^ 24'h800000, 24'hFFFFFF);
    // self and system offset calibrations store the modulator value
    raw2 = rnd();
    raw_result <= raw2;
    op(8'h90);
    rd(RS_STATUS, 24'h000002, 24'h000002);
    repeat (CONV) @(posedge clk_sys);
    op(8'hA0);
    repeat (CONV + 10) @(posedge clk_sys);
    rd(RS_SELF_OFF, raw2, 24'hFFFFFF);
    rd(RS_SYS_OFF, raw2, 24'hFFFFFF);
    raw1 = rnd();
    raw_result <= raw1;
    raw_under <= 1'b0;
    // unipolar, continuous
    wr(RS_CONFIG, 24'h000040);
    op(8'h83);
    i_asr_host_bfm.wait_rdy(cyc);
    check({23'h0, cyc > 3 * CONV + 10 && cyc < 4 * CONV + 20}, 24'h1);
    rd(RS_RESULT, raw1, 24'hFFFFFF);
    op(8'h88);
    rd(RS_STATUS, 24'h000000, 24'h000002);
    $display("calibration and continuous test done");
    // bipolar two's complement, single cycle
    wr(RS_CONFIG, 24'h000002);
    raw2 = rnd();
    raw_result <= raw2;
    op(8'h83);
    i_asr_host_bfm.wait_rdy(cyc);
    rd(RS_RESULT, raw2, 24'hFFFFFF);
    $display("two's complement test done");
    test_done();
  end
endmodule  // testbench
